// file: rtl/sadc_conv_ctrl.sv
//Contract
// - Amplifier enable lives in bit 7 of amplifier control; 1 enables.
// - Low bits of amplifier control hold the gain-select code, code zero lowest.
// - Conversion starts are limited to 100 ksps at most.
// - SAR clock is the system clock divided by the clock-period field plus one; the divider ticks every period+1 system clocks.
// - Start mode picks busy write, timer 3 overflow, external rising edge, timer 2 overflow.
// - Busy reads 1 during a conversion and 0 once it completes.
// - Busy falling sets the done flag, bit 5, and requests an interrupt when enabled.
// - Result sits in high and low bytes, left or right justified per bit.
// - Tracking-mode 0 tracks the input whenever no conversion runs.
// - Tracking-mode 1 tracks 3 SAR clocks after each start before converting.
// - Low-power with external start tracks while input low, converts on rising edge.
// - Tracking is suspended while the chip is in standby or sleep.
`timescale 1ns/1ns
`default_nettype none
module sadc_conv_ctrl
   import sadc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [7:0]           sfr_addr,
   input  wire logic                 sfr_wr_en,
   input  wire logic [7:0]           sfr_wr_data,
   output var  logic [7:0]           sfr_rd_data,
   input  wire logic                 timer2_ovf,
   input  wire logic                 timer3_ovf,
   input  wire logic                 ext_convert_start,
   input  wire logic                 chip_standby,
   input  wire logic                 sar_cmp_in,
   input  wire logic                 irq_enable,
   output var  logic                 hv_amp_enable,
   output var  logic [HV_GAIN_W-1:0] hv_amp_gain_code,
   output var  logic [CFG_PGA_W-1:0] pga_gain_code,
   output var  logic                 track_en,
   output var  logic [RES_W-1:0]     sar_trial_code,
   output var  logic                 conversion_busy,
   output var  logic                 conv_done_irq_req
);

   function automatic logic wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] target);
      wr_hit = en && (addr == target);
   endfunction

   // Register fields
   logic                  amp_en_r,   amp_en_nxt;
   logic [HV_GAIN_W-1:0]  amp_gain_r, amp_gain_nxt;
   logic [CFG_PER_W-1:0]  period_r,   period_nxt;
   logic [CFG_PGA_W-1:0]  pga_r,      pga_nxt;
   logic                  conv_en_r,  conv_en_nxt;
   logic                  tm_r,       tm_nxt;
   logic                  done_r,     done_nxt;
   logic                  busy_r,     busy_nxt;
   sadc_start_t           mode_r,     mode_nxt;
   logic                  win_r,      win_nxt;
   logic                  ljst_r,     ljst_nxt;

   // Sequencer state
   sadc_state_t           state_r,    state_nxt;
   logic [TRK_W-1:0]      trk_cnt_r,  trk_cnt_nxt;
   logic [IDX_W-1:0]      idx_r,      idx_nxt;
   logic [RES_W-1:0]      trial_r,    trial_nxt;
   logic [RES_W-1:0]      result_r,   result_nxt;
   logic [RATE_CNT_W-1:0] rate_cnt_r, rate_cnt_nxt;
   logic [7:0]            rd_r,       rd_nxt;

   // External start synchroniser
   logic                  ext_meta_r;
   logic                  ext_sync_r;
   logic                  ext_prev_r;
   logic                  ext_rise;

   logic                  wr_amp;
   logic                  wr_cfg;
   logic                  wr_ctrl;
   logic                  sw_start;
   logic                  start_evt;
   logic                  accept;
   logic                  done_set;
   logic                  sar_tick;
   logic [15:0]           just_word;

   assign wr_amp  = wr_hit(sfr_wr_en, sfr_addr, ADDR_HV_AMP);
   assign wr_cfg  = wr_hit(sfr_wr_en, sfr_addr, ADDR_CFG);
   assign wr_ctrl = wr_hit(sfr_wr_en, sfr_addr, ADDR_CTRL);

   sadc_sar_div u_sar_div
   (
      .clk      (clk),
      .resetn   (resetn),
      .period   (period_r),
      .restart  (wr_cfg),
      .sar_tick (sar_tick)
   );

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         // Reset high: a pin idling high must not look like a rise after reset
         ext_meta_r <= 1'b1;
         ext_sync_r <= 1'b1;
         ext_prev_r <= 1'b1;
      end
      else
      begin
         ext_meta_r <= ext_convert_start;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
      end
   end

   assign ext_rise = ext_sync_r && !ext_prev_r;

   // Busy write only starts when both the current mode and the mode written alongside are software mode
   assign sw_start = wr_ctrl && sfr_wr_data[CTRL_BUSY_BIT]
                     && (sfr_wr_data[CTRL_MODE_LSB +: 2] == SADC_SM_BUSY);

   always_comb
   begin
      case (mode_r)
         SADC_SM_BUSY: start_evt = sw_start;
         SADC_SM_TMR3: start_evt = timer3_ovf;
         SADC_SM_EXT:  start_evt = ext_rise;
         SADC_SM_TMR2: start_evt = timer2_ovf;
         default:      start_evt = 1'b0;
      endcase
   end

   // Dropped starts are not queued: a source must retry after busy clears and the rate counter reaches zero
   assign accept = start_evt && conv_en_r && !busy_r && (rate_cnt_r == RATE_ZERO);

   assign just_word = ljst_r ? {result_r, {JUST_PAD_W{1'b0}}}
                             : {{JUST_PAD_W{1'b0}}, result_r};

   always_comb
   begin
      amp_en_nxt   = amp_en_r;
      amp_gain_nxt = amp_gain_r;
      period_nxt   = period_r;
      pga_nxt      = pga_r;
      conv_en_nxt  = conv_en_r;
      tm_nxt       = tm_r;
      busy_nxt     = busy_r;
      mode_nxt     = mode_r;
      win_nxt      = win_r;
      ljst_nxt     = ljst_r;
      state_nxt    = state_r;
      trk_cnt_nxt  = trk_cnt_r;
      idx_nxt      = idx_r;
      trial_nxt    = trial_r;
      result_nxt   = result_r;
      rate_cnt_nxt = rate_cnt_r;
      done_set     = 1'b0;

      if (rate_cnt_r != RATE_ZERO)
      begin
         rate_cnt_nxt = rate_cnt_r - RATE_CNT_W'(1);
      end

      if (wr_amp)
      begin
         amp_en_nxt   = sfr_wr_data[HV_EN_BIT];
         amp_gain_nxt = sfr_wr_data[HV_GAIN_LSB +: HV_GAIN_W];
      end
      if (wr_cfg)
      begin
         period_nxt = sfr_wr_data[CFG_PER_LSB +: CFG_PER_W];
         pga_nxt    = sfr_wr_data[CFG_PGA_LSB +: CFG_PGA_W];
      end
      if (wr_ctrl)
      begin
         conv_en_nxt = sfr_wr_data[CTRL_EN_BIT];
         tm_nxt      = sfr_wr_data[CTRL_TM_BIT];
         mode_nxt    = sadc_start_t'(sfr_wr_data[CTRL_MODE_LSB +: 2]);
         win_nxt     = sfr_wr_data[CTRL_WIN_BIT];
         ljst_nxt    = sfr_wr_data[CTRL_LJST_BIT];
      end

      case (state_r)
         SADC_ST_IDLE:
         begin
            if (accept)
            begin
               busy_nxt     = 1'b1;
               rate_cnt_nxt = RATE_LOAD;
               // External start already tracked while the pin was low
               if (tm_r && (mode_r != SADC_SM_EXT))
               begin
                  state_nxt   = SADC_ST_TRACK;
                  trk_cnt_nxt = TRK_ZERO;
               end
               else
               begin
                  state_nxt = SADC_ST_CONV;
                  idx_nxt   = IDX_MSB;
                  trial_nxt = '0;
                  trial_nxt[IDX_MSB] = 1'b1;
               end
            end
         end
         SADC_ST_TRACK:
         begin
            if (sar_tick)
            begin
               if (trk_cnt_r == LP_TRACK_LAST)
               begin
                  state_nxt = SADC_ST_CONV;
                  idx_nxt   = IDX_MSB;
                  trial_nxt = '0;
                  trial_nxt[IDX_MSB] = 1'b1;
               end
               else
               begin
                  trk_cnt_nxt = trk_cnt_r + TRK_STEP;
               end
            end
         end
         SADC_ST_CONV:
         begin
            if (sar_tick)
            begin
               trial_nxt[idx_r] = sar_cmp_in;
               if (idx_r == IDX_LSB)
               begin
                  result_nxt         = trial_r;
                  result_nxt[IDX_LSB] = sar_cmp_in;
                  busy_nxt           = 1'b0;
                  done_set           = 1'b1;
                  state_nxt          = SADC_ST_IDLE;
               end
               else
               begin
                  trial_nxt[idx_r - IDX_STEP] = 1'b1;
                  idx_nxt = idx_r - IDX_STEP;
               end
            end
         end
         default:
         begin
            state_nxt = SADC_ST_IDLE;
            busy_nxt  = 1'b0;
         end
      endcase

      // Completion beats a software clear in the same cycle
      if (done_set)
      begin
         done_nxt = 1'b1;
      end
      else if (wr_ctrl)
      begin
         done_nxt = sfr_wr_data[CTRL_DONE_BIT];
      end
      else
      begin
         done_nxt = done_r;
      end

      case (sfr_addr)
         ADDR_HV_AMP: rd_nxt = {amp_en_r, 3'h0, amp_gain_r};
         ADDR_CFG:    rd_nxt = {period_r, pga_r};
         ADDR_CTRL:   rd_nxt = {conv_en_r, tm_r, done_r, busy_r, mode_r, win_r, ljst_r};
         ADDR_RES_HI: rd_nxt = just_word[15:8];
         ADDR_RES_LO: rd_nxt = just_word[7:0];
         default:     rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         amp_en_r   <= HV_RST[HV_EN_BIT];
         amp_gain_r <= HV_RST[HV_GAIN_LSB +: HV_GAIN_W];
         period_r   <= CFG_RST[CFG_PER_LSB +: CFG_PER_W];
         pga_r      <= CFG_RST[CFG_PGA_LSB +: CFG_PGA_W];
         conv_en_r  <= CTRL_RST[CTRL_EN_BIT];
         tm_r       <= CTRL_RST[CTRL_TM_BIT];
         done_r     <= CTRL_RST[CTRL_DONE_BIT];
         busy_r     <= CTRL_RST[CTRL_BUSY_BIT];
         mode_r     <= SADC_SM_BUSY;
         win_r      <= CTRL_RST[CTRL_WIN_BIT];
         ljst_r     <= CTRL_RST[CTRL_LJST_BIT];
         state_r    <= SADC_ST_IDLE;
         trk_cnt_r  <= TRK_ZERO;
         idx_r      <= IDX_MSB;
         trial_r    <= '0;
         result_r   <= '0;
         rate_cnt_r <= RATE_ZERO;
         rd_r       <= 8'h00;
      end
      else
      begin
         amp_en_r   <= amp_en_nxt;
         amp_gain_r <= amp_gain_nxt;
         period_r   <= period_nxt;
         pga_r      <= pga_nxt;
         conv_en_r  <= conv_en_nxt;
         tm_r       <= tm_nxt;
         done_r     <= done_nxt;
         busy_r     <= busy_nxt;
         mode_r     <= mode_nxt;
         win_r      <= win_nxt;
         ljst_r     <= ljst_nxt;
         state_r    <= state_nxt;
         trk_cnt_r  <= trk_cnt_nxt;
         idx_r      <= idx_nxt;
         trial_r    <= trial_nxt;
         result_r   <= result_nxt;
         rate_cnt_r <= rate_cnt_nxt;
         rd_r       <= rd_nxt;
      end
   end

   // Tracking switch; standby overrides every mode
   always_comb
   begin
      if (chip_standby)
      begin
         track_en = 1'b0;
      end
      else if (!tm_r)
      begin
         track_en = !busy_r;
      end
      else if (mode_r == SADC_SM_EXT)
      begin
         track_en = !busy_r && !ext_sync_r;
      end
      else
      begin
         track_en = (state_r == SADC_ST_TRACK);
      end
   end

   assign sfr_rd_data       = rd_r;
   assign hv_amp_enable     = amp_en_r;
   assign hv_amp_gain_code  = amp_gain_r;
   assign pga_gain_code     = pga_r;
   assign sar_trial_code    = trial_r;
   assign conversion_busy   = busy_r;
   assign conv_done_irq_req = done_r && irq_enable;

endmodule
`default_nettype wire

// file: rtl/sadc_pkg.sv
`default_nettype none
package sadc_pkg;

   // System clock and conversion rate ceiling
   localparam int CLK_HZ          = 100_000_000;
   localparam int MAX_RATE_SPS    = 100_000;
   localparam int MIN_CONV_CYCLES = CLK_HZ / MAX_RATE_SPS;
   localparam int RATE_CNT_W      = 10;
   localparam logic [RATE_CNT_W-1:0] RATE_LOAD = RATE_CNT_W'(MIN_CONV_CYCLES - 1);
   localparam logic [RATE_CNT_W-1:0] RATE_ZERO = '0;

   // Converter geometry
   localparam int RES_W      = 12;
   localparam int IDX_W      = 4;
   localparam int JUST_PAD_W = 16 - RES_W;
   localparam logic [IDX_W-1:0] IDX_MSB  = IDX_W'(RES_W - 1);
   localparam logic [IDX_W-1:0] IDX_LSB  = 4'h0;
   localparam logic [IDX_W-1:0] IDX_STEP = 4'h1;

   // Low-power tracking length in SAR clocks
   localparam int TRK_W = 2;
   localparam logic [TRK_W-1:0] LP_TRACK_LAST = TRK_W'(3 - 1);
   localparam logic [TRK_W-1:0] TRK_ZERO      = '0;
   localparam logic [TRK_W-1:0] TRK_STEP      = 2'h1;

   // Register addresses
   localparam logic [7:0] ADDR_HV_AMP = 8'hd6;
   localparam logic [7:0] ADDR_CFG    = 8'hbc;
   localparam logic [7:0] ADDR_CTRL   = 8'he8;
   localparam logic [7:0] ADDR_RES_HI = 8'hbf;
   localparam logic [7:0] ADDR_RES_LO = 8'hbe;

   // Amplifier control fields
   localparam int HV_EN_BIT   = 7;
   localparam int HV_GAIN_LSB = 0;
   localparam int HV_GAIN_W   = 4;
   localparam logic [7:0] HV_RST = 8'h00;

   // Configuration fields
   localparam int CFG_PER_LSB = 3;
   localparam int CFG_PER_W   = 5;
   localparam int CFG_PGA_LSB = 0;
   localparam int CFG_PGA_W   = 3;
   localparam logic [7:0] CFG_RST = 8'hf8;

   // Control fields
   localparam int CTRL_EN_BIT   = 7;
   localparam int CTRL_TM_BIT   = 6;
   localparam int CTRL_DONE_BIT = 5;
   localparam int CTRL_BUSY_BIT = 4;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_WIN_BIT  = 1;
   localparam int CTRL_LJST_BIT = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   typedef enum logic [1:0]
   {
      SADC_SM_BUSY = 2'b00,
      SADC_SM_TMR3 = 2'b01,
      SADC_SM_EXT  = 2'b10,
      SADC_SM_TMR2 = 2'b11
   } sadc_start_t;

   typedef enum logic [1:0]
   {
      SADC_ST_IDLE  = 2'b00,
      SADC_ST_TRACK = 2'b01,
      SADC_ST_CONV  = 2'b10
   } sadc_state_t;

endpackage
`default_nettype wire

// file: rtl/sadc_sar_div.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_sar_div
   import sadc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [CFG_PER_W-1:0] period,
   input  wire logic                 restart,
   output var  logic                 sar_tick
);

   logic [CFG_PER_W-1:0] cnt_r;
   logic [CFG_PER_W-1:0] cnt_nxt;
   logic                 tick_r;
   logic                 tick_nxt;

   // One tick every period+1 system clocks; restart realigns the phase
   always_comb
   begin
      cnt_nxt  = cnt_r + CFG_PER_W'(1);
      tick_nxt = 1'b0;
      if (restart)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r >= period)
      begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign sar_tick = tick_r;

endmodule
`default_nettype wire

// file: testbench/sadc_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_chk
   import sadc_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic [7:0]           sfr_addr,
   input wire logic                 sfr_wr_en,
   input wire logic [7:0]           sfr_wr_data,
   input wire logic                 timer2_ovf,
   input wire logic                 timer3_ovf,
   input wire logic                 ext_convert_start,
   input wire logic                 chip_standby,
   input wire logic                 irq_enable,
   input wire logic                 hv_amp_enable,
   input wire logic [HV_GAIN_W-1:0] hv_amp_gain_code,
   input wire logic                 track_en,
   input wire logic [RES_W-1:0]     sar_trial_code,
   input wire logic                 conversion_busy,
   input wire logic                 conv_done_irq_req
);
   logic       tm_r;
   logic       tm_nxt;
   logic       bq_r;
   logic [1:0] md_r;
   logic [1:0] md_nxt;
   logic [9:0] gap_r;
   logic [9:0] gap_nxt;
   logic       cw;

   assign cw = sfr_wr_en && sfr_addr == ADDR_CTRL;

   // Cycles since the last busy rise, saturating
   always_comb
   begin
      tm_nxt  = cw ? sfr_wr_data[CTRL_TM_BIT] : tm_r;
      md_nxt  = cw ? sfr_wr_data[CTRL_MODE_LSB +: 2] : md_r;
      gap_nxt = gap_r + {9'h000, gap_r != 10'h3ff};
      if (conversion_busy && !bq_r)
         gap_nxt = 10'h000;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tm_r  <= 1'b0;
         md_r  <= 2'h0;
         bq_r  <= 1'b0;
         gap_r <= 10'h3ff;
      end
      else
      begin
         tm_r  <= tm_nxt;
         md_r  <= md_nxt;
         bq_r  <= conversion_busy;
         gap_r <= gap_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   start_cause_a:
      assert property ($rose(conversion_busy) |-> $past(cw && sfr_wr_data[CTRL_BUSY_BIT] || timer2_ovf
         || timer3_ovf || ext_convert_start)) else $error("busy rose without start");
   done_flag_a:
      assert property ($fell(conversion_busy) && irq_enable |-> conv_done_irq_req) else $error("no done flag");
   irq_gate_a:
      assert property (!irq_enable |-> !conv_done_irq_req) else $error("request while masked");
   rate_gap_a:
      assert property ($rose(conversion_busy) |-> gap_r >= 10'd999) else $error("starts too close");
   standby_track_a:
      assert property (chip_standby |-> !track_en) else $error("tracking in standby");
   idle_track_a:
      assert property (!tm_r && !conversion_busy && !chip_standby |-> track_en) else $error("idle not tracking");
   conv_track_a:
      assert property (!tm_r && conversion_busy |-> !track_en) else $error("tracking in conversion");
   lp_idle_a:
      assert property (tm_r && md_r != SADC_SM_EXT && !conversion_busy |-> !track_en)
      else $error("low power idle tracking");
   first_trial_a:
      assert property ($rose(conversion_busy) && !tm_r |-> sar_trial_code == 12'h800) else $error("bad first trial");
   amp_write_a:
      assert property (sfr_wr_en && sfr_addr == ADDR_HV_AMP |=> hv_amp_enable == $past(sfr_wr_data[HV_EN_BIT])
         && hv_amp_gain_code == $past(sfr_wr_data[3:0])) else $error("amp register not updated");
endmodule

bind sadc_conv_ctrl sadc_chk i_sadc_chk (.clk, .resetn, .sfr_addr, .sfr_wr_en, .sfr_wr_data, .timer2_ovf,
   .timer3_ovf, .ext_convert_start, .chip_standby, .irq_enable, .hv_amp_enable, .hv_amp_gain_code, .track_en,
   .sar_trial_code, .conversion_busy, .conv_done_irq_req);
`default_nettype wire

// file: testbench/sadc_start_src.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_start_src
   import sadc_pkg::*;
(
   input  wire logic clk,
   output var  logic timer2_ovf,
   output var  logic timer3_ovf,
   output var  logic ext_convert_start
);
   initial
   begin
      timer2_ovf        = 1'b0;
      timer3_ovf        = 1'b0;
      ext_convert_start = 1'b1;
   end

   task automatic pin(input logic v);
      @(posedge clk);
      ext_convert_start <= v;
   endtask

   // Timers pulse for one cycle; the pin is a level held by the source
   task automatic fire(input sadc_start_t m, input int hold);
      if (m == SADC_SM_EXT)
      begin
         pin(1'b0);
         repeat (hold) @(posedge clk);
         pin(1'b1);
      end
      else
      begin
         @(posedge clk);
         timer3_ovf <= m == SADC_SM_TMR3;
         timer2_ovf <= m == SADC_SM_TMR2;
         @(posedge clk);
         timer3_ovf <= 1'b0;
         timer2_ovf <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import sadc_pkg::*;
   logic                      clk;
   logic                      resetn;
   logic [7:0]                sfr_addr;
   logic                      sfr_wr_en;
   logic [7:0]                sfr_wr_data;
   logic                      chip_standby;
   logic                      irq_enable;
   logic [RES_W-1:0]          vin;
   logic [7:0]                d;
   int                        err_total;
   int                        num_checks;
   int                        n;
   int                        j;
   int                        k;
   wire logic [7:0]           sfr_rd_data;
   wire logic                 timer2_ovf;
   wire logic                 timer3_ovf;
   wire logic                 ext_convert_start;
   wire logic                 sar_cmp_in;
   wire logic                 hv_amp_enable;
   wire logic [HV_GAIN_W-1:0] hv_amp_gain_code;
   wire logic [CFG_PGA_W-1:0] pga_gain_code;
   wire logic                 track_en;
   wire logic [RES_W-1:0]     sar_trial_code;
   wire logic                 conversion_busy;
   wire logic                 conv_done_irq_req;

   // Ideal comparator, so the search must land exactly on vin
   assign sar_cmp_in = vin >= sar_trial_code;

   sadc_conv_ctrl i_sadc_conv_ctrl (.clk, .resetn, .sfr_addr, .sfr_wr_en, .sfr_wr_data, .sfr_rd_data, .timer2_ovf,
      .timer3_ovf, .ext_convert_start, .chip_standby, .sar_cmp_in, .irq_enable, .hv_amp_enable, .hv_amp_gain_code,
      .pga_gain_code, .track_en, .sar_trial_code, .conversion_busy, .conv_done_irq_req);
   sadc_start_src i_sadc_start_src (.clk, .timer2_ovf, .timer3_ovf, .ext_convert_start);

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rng(input string nm, input int lo, input int hi, input int g);
      num_checks++;
      if (g < lo || g > hi)
      begin
         err_total++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      sfr_addr    <= a;
      sfr_wr_data <= v;
      sfr_wr_en   <= 1'b1;
      @(posedge clk);
      sfr_wr_en   <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      sfr_addr <= a;
      @(posedge clk);
      #1 d = sfr_rd_data;
   endtask

   // Bounded wait for a busy level; n returns the cycles taken
   task automatic wt(input logic v, input int lim);
      n = 0;
      #1;
      while (conversion_busy !== v && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim)
         chk("busy_wait", 16'(v), 16'(conversion_busy));
   endtask

   task automatic res(input logic lj);
      rd(ADDR_RES_HI);
      chk("res_hi", lj ? {8'h00, vin[11:4]} : {12'h000, vin[11:8]}, 16'(d));
      rd(ADDR_RES_LO);
      chk("res_lo", lj ? {8'h00, vin[3:0], 4'h0} : {8'h00, vin[7:0]}, 16'(d));
   endtask

   task automatic no_start(input string nm);
      repeat (12) @(posedge clk);
      #1 chk(nm, 16'h0000, 16'(conversion_busy));
   endtask

   task automatic done_t(input string nm);
      $display("test %s done, mismatches so far %0d", nm, err_total);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // About ten thousand cycles expected
   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      report_and_stop;
   end

   initial
   begin
      resetn       = 1'b0;
      sfr_addr     = 8'h00;
      sfr_wr_en    = 1'b0;
      sfr_wr_data  = 8'h00;
      chip_standby = 1'b0;
      irq_enable   = 1'b1;
      vin          = 12'ha5c;
      err_total    = 0;
      num_checks   = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(ADDR_HV_AMP);
      chk("amp_rst", 16'(HV_RST), 16'(d));
      rd(ADDR_CFG);
      chk("cfg_rst", 16'(CFG_RST), 16'(d));
      rd(ADDR_CTRL);
      chk("ctrl_rst", 16'(CTRL_RST), 16'(d));
      rd(8'h00);
      chk("unmapped", 16'h0000, 16'(d));
      chk("track_idle", 16'h0001, 16'(track_en));
      wr(ADDR_HV_AMP, 8'hfa);
      rd(ADDR_HV_AMP);
      chk("amp_rd", 16'h008a, 16'(d));
      chk("amp_out", 16'h001a, {11'h000, hv_amp_enable, hv_amp_gain_code});
      done_t("registers");

      wr(ADDR_CFG, 8'h0d);
      for (k = 0; k < 2; k++)
      begin
         wr(ADDR_CTRL, {7'h40, k[0]});
         wr(ADDR_CTRL, {7'h48, k[0]});
         chk("pga", 16'h0005, 16'(pga_gain_code));
         wt(1'b1, 4);
         chk("track_conv", 16'h0000, 16'(track_en));
         wt(1'b0, 40);
         rng("conv_len", 22, 25, n);
         d = 8'h00;
         for (j = 0; j < 20 && !d[CTRL_DONE_BIT]; j++)
            rd(ADDR_CTRL);
         chk("ctrl_done", {8'h00, 7'h50, k[0]}, 16'(d));
         chk("irq", 16'h0001, 16'(conv_done_irq_req));
         res(k[0]);
         repeat (1000) @(posedge clk);
      end
      @(posedge clk);
      irq_enable <= 1'b0;
      @(posedge clk);
      #1 chk("irq_mask", 16'h0000, 16'(conv_done_irq_req));
      @(posedge clk);
      irq_enable <= 1'b1;
      wr(ADDR_CTRL, 8'h80);
      rd(ADDR_CTRL);
      chk("irq_clr", 16'h0000, 16'(conv_done_irq_req));
      done_t("software");

      for (k = 1; k < 4; k++)
      begin
         wr(ADDR_CTRL, {4'h8, k[1:0], 2'b00});
         i_sadc_start_src.fire(k == 1 ? SADC_SM_TMR2 : SADC_SM_TMR3, 16);
         no_start("wrong_src");
         i_sadc_start_src.fire(sadc_start_t'(k[1:0]), 16);
         wt(1'b1, 8);
         // Timer pulse is taken at the edge fire returns on; the pin needs 3 sync edges
         rng("start_lat", k == 2 ? 3 : 0, k == 2 ? 3 : 0, n);
         wt(1'b0, 40);
         repeat (1000) @(posedge clk);
      end
      done_t("modes");

      wr(ADDR_CTRL, 8'h84);
      i_sadc_start_src.fire(SADC_SM_TMR3, 1);
      wt(1'b1, 4);
      i_sadc_start_src.fire(SADC_SM_TMR3, 1);
      wt(1'b0, 40);
      rng("len_with_restart", 22, 25, n + 2);
      res(1'b0);
      i_sadc_start_src.fire(SADC_SM_TMR3, 1);
      no_start("rate_drop");
      repeat (1000) @(posedge clk);
      i_sadc_start_src.fire(SADC_SM_TMR3, 1);
      wt(1'b1, 4);
      wt(1'b0, 40);
      done_t("rate");

      wr(ADDR_CFG, 8'h1d);
      wr(ADDR_CTRL, 8'hc4);
      wr(ADDR_HV_AMP, 8'h83);
      repeat (1000) @(posedge clk);
      #1 chk("lp_idle", 16'h0000, 16'(track_en));
      i_sadc_start_src.fire(SADC_SM_TMR3, 1);
      j = 0;
      k = 0;
      repeat (100)
      begin
         @(posedge clk);
         #1;
         j += int'(conversion_busy === 1'b1 && track_en === 1'b1);
         k += int'(conversion_busy === 1'b1);
      end
      rng("lp_track", 9, 12, j);
      rng("lp_len", 56, 61, k);
      res(1'b0);

      wr(ADDR_CTRL, 8'hc8);
      repeat (1000) @(posedge clk);
      i_sadc_start_src.pin(1'b0);
      repeat (6) @(posedge clk);
      #1 chk("ext_track", 16'h0001, 16'(track_en));
      chk("ext_wait", 16'h0000, 16'(conversion_busy));
      i_sadc_start_src.pin(1'b1);
      wt(1'b1, 8);
      rng("sync_lat", 3, 5, n);
      chk("ext_conv", 16'h0000, 16'(track_en));
      wt(1'b0, 80);
      wr(ADDR_CTRL, 8'h80);
      @(posedge clk);
      chip_standby <= 1'b1;
      #1 chk("standby", 16'h0000, 16'(track_en));
      @(posedge clk);
      chip_standby <= 1'b0;
      done_t("tracking");
      report_and_stop;
   end
endmodule
`default_nettype wire
